// >>> logic/sdd_ctrl.sv
// Top of the supply-drop detector control: registers, flag, reset and interrupt paths.
// Assumes reset_n carries every reset except the detector's own internal reset,
// and that software follows the documented start and stop sequences.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sdd_ctrl
   import sdd_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clkEn,
   // Register port.
   input wire sdd_bus_req_t busReq,
   output logic [DATA_W-1:0] rdData_q,
   // Comparator side.
   input wire logic supplyBelow,
   output logic [THR_W-1:0] thresholdCode_q,
   output logic comparatorEnable_q,
   // Requests to the system.
   output logic detectorIrq_q,
   output logic detectorReset_q,
   output logic irq_q
);
   logic ctrlSpare_q;
   logic ctrlMode_q;
   logic flag_q;
   logic cause_q;
   logic [CNT_W-1:0] settleCnt_q;
   sdd_state_t state_q;
   sdd_state_t stateD;
   logic syncBelow;
   logic [EVT_W-1:0] status;
   logic [EVT_W-1:0] mask;

   // Register decode.
   wire wrCtrl = busReq.wrStb && (busReq.addr == REG_CTRL);
   wire wrThresh = busReq.wrStb && (busReq.addr == REG_THRESH);
   wire wrMask = busReq.wrStb && (busReq.addr == REG_MASK);
   wire rdStatus = busReq.rdStb && (busReq.addr == REG_STATUS);
   wire rdCause = busReq.rdStb && (busReq.addr == REG_CAUSE);
   wire [THR_W-1:0] wrCode = busReq.wrData[THR_W-1:0];
   wire thrLegal = (wrCode <= THR_MAX) && (busReq.wrData[DATA_W-1:THR_W] == '0);

   // Detector outputs, all but the settle event derived from the synchronised comparator.
   // flag only when enabled.
   wire flagD = comparatorEnable_q & syncBelow;
   wire irqReqD = flagD & ~ctrlMode_q;
   wire resetReqD = flagD & ctrlMode_q;
   wire causeD = resetReqD | (cause_q & ~rdCause);
   wire irqRise = irqReqD & ~detectorIrq_q;
   wire cntDone = settleCnt_q == CNT_W'(SETTLE_CYCLES - 1);
   wire settled = (state_q == DET_SETTLING) && comparatorEnable_q && cntDone;
   wire [EVT_W-1:0] events = {settled, irqRise};

   // Read data selection.
   wire [DATA_W-1:0] ctrlView = {comparatorEnable_q, 2'b00, ctrlSpare_q, 2'b00,
                                 ctrlMode_q, flag_q};
   wire [DATA_W-1:0] statusView = {{(DATA_W-EVT_W){1'b0}}, status};
   wire [DATA_W-1:0] maskView = {{(DATA_W-EVT_W){1'b0}}, mask};
   wire [DATA_W-1:0] causeView = {{(DATA_W-1){1'b0}}, cause_q};
   wire [DATA_W-1:0] threshView = {{(DATA_W-THR_W){1'b0}}, thresholdCode_q};
   wire [DATA_W-1:0] rdMux = (busReq.addr == REG_CTRL) ? ctrlView :
                             (busReq.addr == REG_THRESH) ? threshView :
                             (busReq.addr == REG_STATUS) ? statusView :
                             (busReq.addr == REG_MASK) ? maskView :
                             (busReq.addr == REG_CAUSE) ? causeView : RD_IDLE;

   sdd_sync uSync (
      .clock(clock),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .asyncIn(supplyBelow),
      .syncOut_q(syncBelow)
   );

   sdd_irq uIrq (
      .clock(clock),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .evt(events),
      .rdClear(rdStatus),
      .wrMask(wrMask),
      .maskData(busReq.wrData[EVT_W-1:0]),
      .status_q(status),
      .mask_q(mask),
      .irq_q(irq_q)
   );

   // Settle tracking: reports when the comparator wait has elapsed after enabling.
   always_comb begin
      stateD = state_q;
      case (state_q)
         DET_OFF: begin
            stateD = comparatorEnable_q ? DET_SETTLING : DET_OFF;
         end
         DET_SETTLING: begin
            if (!comparatorEnable_q) begin
               stateD = DET_OFF;
            end else if (cntDone) begin
               stateD = ctrlMode_q ? DET_RST_MODE : DET_IRQ_MODE;
            end
         end
         DET_IRQ_MODE, DET_RST_MODE: begin
            if (!comparatorEnable_q) begin
               stateD = DET_OFF;
            end else begin
               stateD = ctrlMode_q ? DET_RST_MODE : DET_IRQ_MODE;
            end
         end
         default: begin
            stateD = DET_OFF;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= DET_OFF;
         settleCnt_q <= '0;
      end else if (clkEn) begin
         state_q <= stateD;
         settleCnt_q <= (state_q == DET_SETTLING && !cntDone) ? settleCnt_q + 1'b1 : '0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         comparatorEnable_q <= 1'b0;
         ctrlMode_q <= 1'b0;
         ctrlSpare_q <= 1'b0;
      end else if (clkEn && wrCtrl) begin
         comparatorEnable_q <= busReq.wrData[CTRL_EN_BIT];
         ctrlMode_q <= busReq.wrData[CTRL_MODE_BIT];
         ctrlSpare_q <= busReq.wrData[CTRL_SPARE_BIT];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         thresholdCode_q <= THR_RESET;
      end else if (clkEn && wrThresh && thrLegal) begin
         thresholdCode_q <= wrCode;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flag_q <= 1'b0;
         detectorIrq_q <= 1'b0;
         detectorReset_q <= 1'b0;
         cause_q <= 1'b0;
      end else if (clkEn) begin
         flag_q <= flagD;
         detectorIrq_q <= irqReqD;
         detectorReset_q <= resetReqD;
         cause_q <= causeD;
      end
   end

   // Read data stand for exactly the cycle after the strobe.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdData_q <= RD_IDLE;
      end else if (clkEn) begin
         rdData_q <= busReq.rdStb ? rdMux : RD_IDLE;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   sequence armedLow_s;
      clkEn && comparatorEnable_q && syncBelow;
   endsequence

   sequence resetModeLow_s;
      armedLow_s ##0 ctrlMode_q;
   endsequence

   sequence irqModeLow_s;
      armedLow_s ##0 !ctrlMode_q;
   endsequence

   reset_mode_a: assert property (resetModeLow_s |=> detectorReset_q && !detectorIrq_q)
      else $error("Undervoltage in reset mode did not give the internal reset.");
   irq_mode_a: assert property (irqModeLow_s |=> detectorIrq_q && !detectorReset_q)
      else $error("Undervoltage in interrupt mode did not give the request.");
   no_false_reset_a: assert property (
      clkEn && !syncBelow |=> !detectorReset_q)
      else $error("Internal reset asserted with the supply above threshold.");
   cause_recorded_a: assert property (
      detectorReset_q |-> cause_q ##1 (cause_q || $past(rdCause)))
      else $error("Detector reset did not record its cause bit.");
   pending_early_a: assert property (
      $rose(detectorIrq_q) |-> status[EVT_PEND_BIT])
      else $error("Request rise did not set the pending bit.");
   flag_disabled_a: assert property (
      clkEn && !comparatorEnable_q |=> !flag_q)
      else $error("Flag set while the detector is disabled.");
   flag_follows_a: assert property (armedLow_s |=> flag_q)
      else $error("Flag clear while enabled and below threshold.");
   ctrl_kept_a: assert property (
      $fell(comparatorEnable_q) || $fell(ctrlMode_q) |-> $past(wrCtrl && clkEn))
      else $error("Enable or mode cleared without a control write.");
   thresh_legal_a: assert property (thresholdCode_q <= THR_MAX)
      else $error("Threshold holds a prohibited code.");
endmodule
`default_nettype wire

// >>> logic/sdd_irq.sv
// Sticky event status, mask and level interrupt of the detector.
// Assumes one-cycle event pulses; a status read clears, a set in that cycle wins.
`timescale 1ns/1ps
`default_nettype none
module sdd_irq
   import sdd_pkg::*;
(
   // Clock and control.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clkEn,
   // Events and software access.
   input wire logic [EVT_W-1:0] evt,
   input wire logic rdClear,
   input wire logic wrMask,
   input wire logic [EVT_W-1:0] maskData,
   // State.
   output logic [EVT_W-1:0] status_q,
   output logic [EVT_W-1:0] mask_q,
   output logic irq_q
);
   logic [EVT_W-1:0] statusD;
   logic [EVT_W-1:0] maskD;
   logic postReset_q;

   genvar i;
   generate
      for (i = 0; i < EVT_W; i++) begin : gBit
         assign statusD[i] = evt[i] | (status_q[i] & ~rdClear);
         assign maskD[i] = wrMask ? maskData[i] : mask_q[i];
      end
   endgenerate

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= '0;
         mask_q <= MASK_RESET;
         irq_q <= 1'b0;
      end else if (clkEn) begin
         status_q <= statusD;
         mask_q <= maskD;
         irq_q <= |(statusD & ~maskD);
      end
   end

   // Marks the first enabled cycle after reset; frozen like the rest of the state.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         postReset_q <= 1'b1;
      end else if (clkEn) begin
         postReset_q <= 1'b0;
      end
   end

   mask_after_reset_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      postReset_q |-> mask_q[EVT_PEND_BIT])
      else $error("Interrupt mask is not set after an external reset.");
endmodule
`default_nettype wire

// >>> logic/sdd_sync.sv
// Two-stage synchroniser for the asynchronous comparator result.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps
`default_nettype none
module sdd_sync
   import sdd_pkg::*;
(
   // Clock and control.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clkEn,
   // Data.
   input wire logic asyncIn,
   output logic syncOut_q
);
   logic meta_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= 1'b0;
         syncOut_q <= 1'b0;
      end else if (clkEn) begin
         meta_q <= asyncIn;
         syncOut_q <= meta_q;
      end
   end

   property syncDelay_p;
      @(posedge clock) disable iff (!reset_n)
      clkEn ##1 clkEn |=> syncOut_q == $past(asyncIn, 2);
   endproperty
   sync_two_stage_a: assert property (syncDelay_p)
      else $error("Synchroniser output is not the input two edges late.");
endmodule
`default_nettype wire

// >>> shared/sdd_pkg.sv
// Constants, register map and carrier types of the supply-drop detector control.
// Assumes a 25 MHz system clock and a byte-wide register port with registered read data.
package sdd_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int THR_W = 4;
   localparam int EVT_W = 2;
   localparam int CNT_W = 13;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_THRESH = 4'h1;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
   localparam logic [ADDR_W-1:0] REG_MASK = 4'h3;
   localparam logic [ADDR_W-1:0] REG_CAUSE = 4'h4;
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_SPARE_BIT = 4;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_FLAG_BIT = 0;
   localparam int EVT_PEND_BIT = 0;
   localparam int EVT_SETTLE_BIT = 1;
   localparam int CAUSE_UV_BIT = 0;
   localparam logic [THR_W-1:0] THR_MAX = 4'h9;
   localparam logic [THR_W-1:0] THR_RESET = 4'h0;
   localparam logic [EVT_W-1:0] MASK_RESET = 2'h3;
   localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;
   localparam real CLK_MHZ = 25.0;
   localparam real SETTLE_MS = 0.2;
   localparam int SETTLE_CYC = int'($ceil(SETTLE_MS * CLK_MHZ * 1000.0));
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wrData;
      logic wrStb;
      logic rdStb;
   } sdd_bus_req_t;
   typedef enum logic [1:0] {
      DET_OFF = 2'b00,
      DET_SETTLING = 2'b01,
      DET_IRQ_MODE = 2'b10,
      DET_RST_MODE = 2'b11
   } sdd_state_t;
endpackage

// >>> test/tb_supply_drop_detector_ctrl.sv
// Self-checking testbench of the supply-drop detector control top.
// Assumes the package constants and a shortened settling count of 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_supply_drop_detector_ctrl
   import sdd_pkg::*;
;
   localparam int SC = 8;
   logic clock;
   logic reset_n;
   logic clkEn;
   logic supplyBelow;
   sdd_bus_req_t busReq;
   logic [DATA_W-1:0] rdData_q;
   logic [THR_W-1:0] thresholdCode_q;
   logic comparatorEnable_q;
   logic detectorIrq_q;
   logic detectorReset_q;
   logic irq_q;
   logic [7:0] expThr;
   int failCount = 0;
   int checkCount = 0;

   sdd_ctrl #(.SETTLE_CYCLES(SC)) i_dut (
      .clock(clock),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .busReq(busReq),
      .rdData_q(rdData_q),
      .supplyBelow(supplyBelow),
      .thresholdCode_q(thresholdCode_q),
      .comparatorEnable_q(comparatorEnable_q),
      .detectorIrq_q(detectorIrq_q),
      .detectorReset_q(detectorReset_q),
      .irq_q(irq_q)
   );

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checkCount++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
      @(posedge clock);
      busReq.wrStb <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are sampled there.
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
      @(posedge clock);
      busReq <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
      @(posedge clock);
      busReq.rdStb <= 1'b0;
      @(negedge clock);
      check(what, exp, rdData_q);
   endtask

   // Compares enable, request, internal reset and interrupt in that order.
   task automatic pins(input logic [3:0] e);
      @(negedge clock);
      check("pins", {4'h0, e},
         {4'h0, comparatorEnable_q, detectorIrq_q, detectorReset_q, irq_q});
   endtask

   // Leaves time for the two-stage synchroniser and the registered outputs.
   task automatic supply(input logic v);
      @(posedge clock);
      supplyBelow <= v;
      repeat (4) @(posedge clock);
   endtask

   task automatic giveVerdict;
      $display("checks %0d mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge clock);
      failCount++;
      $display("watchdog expired");
      giveVerdict();
   end

   initial begin
      reset_n = 1'b0;
      clkEn = 1'b1;
      supplyBelow = 1'b0;
      busReq = '0;
      expThr = 8'h00;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      rd(REG_CTRL, 8'h00, "ctrl");
      rd(REG_MASK, 8'h03, "mask");
      rd(REG_CAUSE, 8'h00, "cause");
      wr(4'h7, 8'hFF);
      rd(4'h7, 8'h00, "unmapped");
      $display("test reset values done");
      for (int c = 0; c < 16; c++) begin
         wr(REG_THRESH, 8'(c));
         if (c <= 9) expThr = 8'(c);
         rd(REG_THRESH, expThr, "thresh");
         check("code pin", expThr, {4'h0, thresholdCode_q});
      end
      wr(REG_THRESH, 8'h15);
      rd(REG_THRESH, 8'h09, "thresh high bits");
      @(posedge clock);
      clkEn <= 1'b0;
      wr(REG_CTRL, 8'h80);
      @(posedge clock);
      clkEn <= 1'b1;
      rd(REG_CTRL, 8'h00, "frozen write");
      $display("test threshold done");
      wr(REG_CTRL, 8'h80);
      pins(4'b1000);
      repeat (SC + 2) @(posedge clock);
      rd(REG_STATUS, 8'h02, "settled");
      supply(1'b1);
      rd(REG_CTRL, 8'h81, "flag low supply");
      pins(4'b1100);
      wr(REG_MASK, 8'h00);
      pins(4'b1101);
      rd(REG_STATUS, 8'h01, "pending");
      pins(4'b1100);
      supply(1'b0);
      rd(REG_CTRL, 8'h80, "flag good supply");
      pins(4'b1000);
      wr(REG_CTRL, 8'h00);
      supply(1'b1);
      rd(REG_CTRL, 8'h00, "flag disabled");
      pins(4'b0000);
      rd(REG_STATUS, 8'h00, "no pending");
      supply(1'b0);
      $display("test interrupt mode done");
      wr(REG_MASK, 8'h03);
      wr(REG_CTRL, 8'h80);
      repeat (SC + 2) @(posedge clock);
      rd(REG_CTRL, 8'h80, "flag before mode");
      wr(REG_CTRL, 8'h82);
      pins(4'b1000);
      rd(REG_CAUSE, 8'h00, "cause idle");
      supply(1'b1);
      pins(4'b1010);
      rd(REG_CTRL, 8'h83, "ctrl kept");
      rd(REG_CAUSE, 8'h01, "cause set");
      wr(REG_CTRL, 8'h80);
      @(posedge clock);
      pins(4'b1100);
      wr(REG_CTRL, 8'h00);
      @(posedge clock);
      pins(4'b0000);
      wr(REG_CTRL, 8'h90);
      rd(REG_CTRL, 8'h91, "spare kept");
      $display("test reset mode done");
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      repeat (SC) @(posedge clock);
      rd(REG_CTRL, 8'h00, "ctrl after reset");
      rd(REG_MASK, 8'h03, "mask after reset");
      pins(4'b0000);
      $display("test external reset done");
      giveVerdict();
   end
endmodule
`default_nettype wire
